// ==== verilog/lsr_status_top.sv ====
// link status and error report outputs with register view and interrupt
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
module lsr_status_top (
  input wire logic clock, // application clock, 50 mhz
  input wire logic rst, // synchronous reset, active high
  input wire logic [4:0] train_state, // training state code from link trainer
  input wire logic [3:0] train_lanes, // lane count settled by training: 1, 2, 4 or 8
  input wire logic rx_par_det, // receive buffer input parity check failed
  input wire logic tx_tl_par_det, // transaction layer transmit parity failed
  input wire logic tx_dl_par_det, // data link layer transmit parity failed
  output logic lp_exit_n, // low-power exit pulse, active low
  output logic [3:0] lane_act, // one-hot lane mode
  output logic [4:0] train_state_out, // training state code
  output logic rx_par_err, // receive parity error pulse
  output logic [1:0] tx_par_err, // transmit parity error code pulse
  output logic tlp_nullify, // nullify the tlp in flight
  output logic irq, // level interrupt
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte lanes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write answer
  output logic s_axi_bvalid, // write answer valid
  input wire logic s_axi_bready, // write answer ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read answer
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);
  lsr_reg_if regs (); // strobes between slave and core

  logic [4:0] prev_state_ff; // state code one cycle ago
  logic dl_pend_ff; // data link code waiting behind a transaction code
  logic [lsr_pkg::EV_W-1:0] status_ff; // sticky events
  logic [lsr_pkg::EV_W-1:0] mask_ff; // interrupt enables
  logic [lsr_pkg::VE_W-1:0] verr_ff; // vendor error capability log
  logic [lsr_pkg::EV_W-1:0] events; // this cycle's events
  logic [lsr_pkg::VE_W-1:0] verr_set; // this cycle's log causes
  logic [3:0] nxt_lane; // lane mode decode
  logic lp_event; // l2 idle left for detect
  logic tl_now; // transaction code goes out now
  logic dl_now; // data link code goes out now
  logic wr_status; // write hits status
  logic wr_mask; // write hits mask
  logic wr_verr; // write hits vendor log
  logic [31:0] link_word; // live link view

  // bus slave
  lsr_axil_slave u_slave (
    .clock(clock),
    .rst(rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .regs(regs)
  );

  // low-power exit seen as l2 idle followed by quiet detect
  assign lp_event = (prev_state_ff == lsr_pkg::ST_L2_IDLE) &&
                    (train_state == lsr_pkg::ST_DET_QUIET);

  // transaction code wins a tie, data link code follows next cycle
  assign tl_now = tx_tl_par_det;
  assign dl_now = !tx_tl_par_det && (tx_dl_par_det || dl_pend_ff);

  // track previous state code
  always_ff @(posedge clock) begin
    if (rst) begin
      prev_state_ff <= lsr_pkg::ST_DET_QUIET;
    end else begin
      prev_state_ff <= train_state;
    end
  end

  // state code passes through a flop, codes pass unchanged
  always_ff @(posedge clock) begin
    if (rst) begin
      train_state_out <= lsr_pkg::ST_DET_QUIET;
    end else begin
      train_state_out <= train_state;
    end
  end

  // lane count to one-hot
  always_comb begin
    case (train_lanes)
      4'h1: nxt_lane = lsr_pkg::LANE_X1;
      4'h2: nxt_lane = lsr_pkg::LANE_X2;
      4'h4: nxt_lane = lsr_pkg::LANE_X4;
      4'h8: nxt_lane = lsr_pkg::LANE_X8;
      default: nxt_lane = lsr_pkg::LANE_NONE; // untrained or illegal
    endcase
  end

  // lane mode register
  always_ff @(posedge clock) begin
    if (rst) begin
      lane_act <= lsr_pkg::LANE_NONE;
    end else begin
      lane_act <= nxt_lane;
    end
  end

  // low-power exit pulse, high at rest
  always_ff @(posedge clock) begin
    if (rst) begin
      lp_exit_n <= 1'b1;
    end else begin
      lp_exit_n <= !lp_event;
    end
  end

  // receive parity pulse
  always_ff @(posedge clock) begin
    if (rst) begin
      rx_par_err <= 1'b0;
    end else begin
      rx_par_err <= rx_par_det;
    end
  end

  // transmit parity code and nullify
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_par_err <= lsr_pkg::TXP_NONE;
      tlp_nullify <= 1'b0;
    end else begin
      tlp_nullify <= tl_now;
      if (tl_now) begin
        tx_par_err <= lsr_pkg::TXP_TL;
      end else if (dl_now) begin
        tx_par_err <= lsr_pkg::TXP_DL;
      end else begin
        tx_par_err <= lsr_pkg::TXP_NONE;
      end
    end
  end

  // data link code held one cycle when it meets a transaction code
  always_ff @(posedge clock) begin
    if (rst) begin
      dl_pend_ff <= 1'b0;
    end else begin
      dl_pend_ff <= tx_tl_par_det && (tx_dl_par_det || dl_pend_ff);
    end
  end

  // event vector for the sticky status
  assign events[lsr_pkg::EV_LP_EXIT] = lp_event;
  assign events[lsr_pkg::EV_RX_PAR] = rx_par_det;
  assign events[lsr_pkg::EV_TX_TL] = tl_now;
  assign events[lsr_pkg::EV_TX_DL] = dl_now;

  // causes for the vendor error log
  assign verr_set[lsr_pkg::VE_UNCOR] = rx_par_det || tl_now;
  assign verr_set[lsr_pkg::VE_RX] = rx_par_det;
  assign verr_set[lsr_pkg::VE_TX] = tl_now || dl_now;

  // write decode, low byte lane carries every field
  assign wr_status = regs.wr_en && regs.wr_strb[0] && (regs.wr_addr == lsr_pkg::OFS_STATUS);
  assign wr_mask = regs.wr_en && regs.wr_strb[0] && (regs.wr_addr == lsr_pkg::OFS_MASK);
  assign wr_verr = regs.wr_en && regs.wr_strb[0] && (regs.wr_addr == lsr_pkg::OFS_VERR);
  assign regs.wr_ok = (regs.wr_addr == lsr_pkg::OFS_STATUS) ||
                      (regs.wr_addr == lsr_pkg::OFS_MASK) ||
                      (regs.wr_addr == lsr_pkg::OFS_VERR) ||
                      (regs.wr_addr == lsr_pkg::OFS_LINK);

  // sticky status, a new event beats a clear in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      status_ff <= lsr_pkg::RST_STATUS;
    end else if (wr_status) begin
      status_ff <= (status_ff & ~regs.wr_data[lsr_pkg::EV_W-1:0]) | events;
    end else begin
      status_ff <= status_ff | events;
    end
  end

  // vendor error log, same set-over-clear order
  always_ff @(posedge clock) begin
    if (rst) begin
      verr_ff <= lsr_pkg::RST_VERR;
    end else if (wr_verr) begin
      verr_ff <= (verr_ff & ~regs.wr_data[lsr_pkg::VE_W-1:0]) | verr_set;
    end else begin
      verr_ff <= verr_ff | verr_set;
    end
  end

  // interrupt mask
  always_ff @(posedge clock) begin
    if (rst) begin
      mask_ff <= lsr_pkg::RST_MASK;
    end else if (wr_mask) begin
      mask_ff <= regs.wr_data[lsr_pkg::EV_W-1:0];
    end
  end

  // interrupt level, from flops only
  assign irq = |(status_ff & mask_ff);

  // live link view
  always_comb begin
    link_word = 32'h0000_0000;
    link_word[lsr_pkg::LK_STATE_LSB +: 5] = train_state_out;
    link_word[lsr_pkg::LK_LANE_LSB +: 4] = lane_act;
  end

  // read mux
  always_comb begin
    regs.rd_ok = 1'b1;
    regs.rd_data = 32'h0000_0000;
    case (regs.rd_addr)
      lsr_pkg::OFS_STATUS: regs.rd_data[lsr_pkg::EV_W-1:0] = status_ff;
      lsr_pkg::OFS_MASK: regs.rd_data[lsr_pkg::EV_W-1:0] = mask_ff;
      lsr_pkg::OFS_VERR: regs.rd_data[lsr_pkg::VE_W-1:0] = verr_ff;
      lsr_pkg::OFS_LINK: regs.rd_data = link_word;
      default: regs.rd_ok = 1'b0; // unmapped
    endcase
  end
endmodule

// ==== verilog/lsr_pkg.sv ====
// shared constants for the link status and error report block
package lsr_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00; // sticky event bits, write one to clear
  localparam logic [7:0] OFS_MASK = 8'h04; // interrupt enables, same layout as status
  localparam logic [7:0] OFS_VERR = 8'h08; // vendor error capability log, write one to clear
  localparam logic [7:0] OFS_LINK = 8'h0c; // live training state and lane mode
  // event bit positions in status and mask
  localparam int EV_LP_EXIT = 0; // low-power exit seen
  localparam int EV_RX_PAR = 1; // receive parity error
  localparam int EV_TX_TL = 2; // transmit parity, transaction layer
  localparam int EV_TX_DL = 3; // transmit parity, data link layer
  localparam int EV_W = 4; // number of event bits
  // vendor error capability field positions
  localparam int VE_UNCOR = 0; // uncorrectable internal error
  localparam int VE_RX = 1; // cause: receive path parity
  localparam int VE_TX = 2; // cause: transmit path parity
  localparam int VE_W = 3; // width of the log
  // link register field positions
  localparam int LK_STATE_LSB = 0; // training state code
  localparam int LK_LANE_LSB = 8; // one-hot lane mode
  // reset values
  localparam logic [EV_W-1:0] RST_STATUS = 4'h0; // no events
  localparam logic [EV_W-1:0] RST_MASK = 4'h0; // all masked
  localparam logic [VE_W-1:0] RST_VERR = 3'h0; // nothing logged
  // training state codes
  localparam logic [4:0] ST_DET_QUIET = 5'h00; // quiet detect
  localparam logic [4:0] ST_DET_ACTIVE = 5'h01; // active detect
  localparam logic [4:0] ST_POLL_ACTIVE = 5'h02; // active polling
  localparam logic [4:0] ST_L0 = 5'h0f; // fully operational
  localparam logic [4:0] ST_DISABLE = 5'h10; // link disabled
  localparam logic [4:0] ST_LPBK_ENTRY = 5'h11; // loopback entry
  localparam logic [4:0] ST_L2_IDLE = 5'h15; // deepest low-power idle
  localparam logic [4:0] ST_EQ_DONE = 5'h1f; // recovery equalization complete
  // one-hot lane modes
  localparam logic [3:0] LANE_X1 = 4'h1; // one lane
  localparam logic [3:0] LANE_X2 = 4'h2; // two lanes
  localparam logic [3:0] LANE_X4 = 4'h4; // four lanes
  localparam logic [3:0] LANE_X8 = 4'h8; // eight lanes
  localparam logic [3:0] LANE_NONE = 4'h0; // not trained
  // transmit parity codes
  localparam logic [1:0] TXP_NONE = 2'h0; // quiet
  localparam logic [1:0] TXP_TL = 2'h2; // transaction layer found it
  localparam logic [1:0] TXP_DL = 2'h1; // data link layer found it
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0; // access done
  localparam logic [1:0] RESP_SLVERR = 2'h2; // unmapped address
endpackage

// ==== verilog/lsr_reg_if.sv ====
// register access strobes between bus slave and status core
`timescale 1ns/100ps
interface lsr_reg_if;
  logic wr_en; // one-cycle write strobe
  logic [7:0] wr_addr; // write byte address
  logic [31:0] wr_data; // write data
  logic [3:0] wr_strb; // write byte lanes
  logic wr_ok; // write address is mapped
  logic [7:0] rd_addr; // read byte address
  logic [31:0] rd_data; // read data for rd_addr
  logic rd_ok; // read address is mapped
  modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                 input wr_ok, rd_data, rd_ok);
  modport core (input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                output wr_ok, rd_data, rd_ok);
endinterface

// ==== verilog/lsr_axil_slave.sv ====
// axi4-lite slave turning bus transfers into register strobes
`timescale 1ns/100ps
module lsr_axil_slave (
  input wire logic clock, // application clock
  input wire logic rst, // synchronous reset, active high
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte lanes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write answer
  output logic s_axi_bvalid, // write answer valid
  input wire logic s_axi_bready, // write answer ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read answer
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  lsr_reg_if.slave regs // strobes toward the core
);
  logic aw_held_ff; // write address captured
  logic w_held_ff; // write data captured
  logic [7:0] awaddr_ff; // captured write address
  logic [31:0] wdata_ff; // captured write data
  logic [3:0] wstrb_ff; // captured byte lanes
  logic do_write; // both halves present, answer slot free

  // channels accept independently, stall while an answer is pending
  assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
  assign s_axi_wready = !w_held_ff && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_held_ff && w_held_ff && !s_axi_bvalid;

  // strobes to the core
  assign regs.wr_en = do_write;
  assign regs.wr_addr = awaddr_ff;
  assign regs.wr_data = wdata_ff;
  assign regs.wr_strb = wstrb_ff;
  assign regs.rd_addr = s_axi_araddr;

  // capture write address
  always_ff @(posedge clock) begin
    if (rst) begin
      aw_held_ff <= 1'b0;
      awaddr_ff <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_ff <= 1'b0;
    end
  end

  // capture write data
  always_ff @(posedge clock) begin
    if (rst) begin
      w_held_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_ff <= 1'b0;
    end
  end

  // write answer
  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= lsr_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= regs.wr_ok ? lsr_pkg::RESP_OKAY : lsr_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read answer, data sampled at address acceptance
  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= lsr_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= regs.rd_ok ? regs.rd_data : 32'h0000_0000;
      s_axi_rresp <= regs.rd_ok ? lsr_pkg::RESP_OKAY : lsr_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ==== verification/lsr_status_sva.sv ====
// concurrent checks on the status and parity outputs
`timescale 1ns/100ps
module lsr_status_sva (
  input wire logic clock, // application clock
  input wire logic rst, // synchronous reset
  input wire logic [4:0] train_state, // state code in
  input wire logic [3:0] train_lanes, // lane count in
  input wire logic rx_par_det, // rx parity detect
  input wire logic tx_tl_par_det, // tl parity detect
  input wire logic tx_dl_par_det, // dl parity detect
  input wire logic lp_exit_n, // exit pulse
  input wire logic [3:0] lane_act, // lane mode
  input wire logic [4:0] train_state_out, // state code out
  input wire logic rx_par_err, // rx parity pulse
  input wire logic [1:0] tx_par_err, // tx parity code
  input wire logic tlp_nullify // nullify pulse
);
  logic both_ff; // tl and dl seen together
  // track a same-cycle collision so the pended code is expected
  always_ff @(posedge clock) begin
    if (rst) both_ff <= 1'b0;
    else both_ff <= tx_tl_par_det & tx_dl_par_det;
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  AST_LP_EXIT: assert property (
    train_state_out == lsr_pkg::ST_L2_IDLE && train_state == 5'h00 |-> ##[1:2] !lp_exit_n)
    else $error("exit pulse missing");
  AST_LP_ONE: assert property (
    !lp_exit_n |=> lp_exit_n) else $error("exit pulse too long");
  AST_LANE_HOT: assert property (
    $onehot0(lane_act)) else $error("lane mode not one-hot");
  AST_LANE_MAP: assert property (
    !rst && train_lanes inside {4'h1, 4'h2, 4'h4, 4'h8} |=> lane_act == $past(train_lanes))
    else $error("lane mode wrong");
  AST_STATE: assert property (
    !rst |=> train_state_out == $past(train_state)) else $error("state code wrong");
  AST_RX_PULSE: assert property (
    rx_par_det |=> rx_par_err) else $error("rx parity pulse missing");
  AST_RX_QUIET: assert property (
    !rx_par_det |=> !rx_par_err) else $error("rx parity pulse spurious");
  AST_TX_TL: assert property (
    tx_tl_par_det |=> tx_par_err == lsr_pkg::TXP_TL && tlp_nullify)
    else $error("tl parity code missing");
  AST_TX_DL: assert property (
    tx_dl_par_det && !tx_tl_par_det && !both_ff |=> tx_par_err == lsr_pkg::TXP_DL)
    else $error("dl parity code missing");
  AST_TX_PEND: assert property (
    tx_tl_par_det && tx_dl_par_det |=> tx_par_err == 2'h2 ##1 tx_par_err == 2'h1)
    else $error("pended dl code wrong");
  AST_TX_QUIET: assert property (
    !tx_tl_par_det && !tx_dl_par_det && !both_ff |=> tx_par_err == 2'h0 && !tlp_nullify)
    else $error("tx parity code spurious");
endmodule

// ==== verification/lsr_app_model.sv ====
// application-side model: reset stretch and core reset requests
`timescale 1ns/100ps
module lsr_app_model (
  input wire logic clock, // application clock
  input wire logic rst, // bench reset
  input wire logic lp_exit_n, // exit pulse from core
  input wire logic rx_par_err, // rx parity pulse
  input wire logic [1:0] tx_par_err, // tx parity code
  output logic app_rst, // own internal reset
  output logic core_rst_req // asks for a core reset
);
  logic [5:0] cnt_ff; // internal reset stretch counter
  // hold own reset for 32 cycles after an exit pulse
  always_ff @(posedge clock) begin
    if (rst) cnt_ff <= 6'h00;
    else if (!lp_exit_n) cnt_ff <= 6'h20;
    else if (cnt_ff != 6'h00) cnt_ff <= cnt_ff - 6'h01;
  end
  assign app_rst = (cnt_ff != 6'h00);
  // core state may be unknown after these, so request a reset
  always_ff @(posedge clock) begin
    if (rst) core_rst_req <= 1'b0;
    else if (rx_par_err) core_rst_req <= 1'b1;
    else if (tx_par_err == 2'h1) core_rst_req <= 1'b1;
  end
endmodule

// ==== verification/lsr_status_top_bench.sv ====
// self-checking bench for the link status and error report block
`timescale 1ns/100ps
module lsr_status_top_bench;
  logic clock, rst; // clock and synchronous reset
  logic [4:0] train_state, train_state_out; // state codes in and out
  logic [3:0] train_lanes, lane_act, s_axi_wstrb; // lanes and byte lanes
  logic rx_par_det, tx_tl_par_det, tx_dl_par_det; // parity detect pulses
  logic lp_exit_n, rx_par_err, tlp_nullify, irq; // status outputs
  logic [1:0] tx_par_err, s_axi_bresp, s_axi_rresp, resp; // codes and answers
  logic [7:0] s_axi_awaddr, s_axi_araddr; // bus addresses
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat; // bus data
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready; // write handshakes
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready; // more handshakes
  logic s_axi_rvalid, s_axi_rready, app_rst, core_rst_req; // read handshake, model
  int bad_count, compares, n; // counters
  logic [4:0] st_tab [7] = '{5'h00, 5'h01, 5'h02, 5'h0f, 5'h10, 5'h11, 5'h1f}; // codes
  logic [3:0] ln_tab [7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0, 4'h3, 4'h8}; // lane inputs
  logic [3:0] lx_tab [7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0, 4'h0, 4'h8}; // lane modes
  lsr_status_top u_lsr_status_top (.clock, .rst, .train_state, .train_lanes, .rx_par_det,
    .tx_tl_par_det, .tx_dl_par_det, .lp_exit_n, .lane_act, .train_state_out, .rx_par_err,
    .tx_par_err, .tlp_nullify, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  lsr_app_model u_lsr_app_model (.clock, .rst, .lp_exit_n, .rx_par_err, .tx_par_err,
    .app_rst, .core_rst_req);
  // 50 mhz clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // counts and verdict, then stop
  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // compare a settled single-bit output mid-cycle
  task automatic chk_pin(input logic got, input logic exp, input string what);
    @(negedge clock);
    chk({31'h0, got}, {31'h0, exp}, what);
    @(posedge clock);
  endtask
  // bounded wait ran out
  task automatic hang(input string what);
    chk(32'h0, 32'h1, what);
    wrap_up;
  endtask
  // axi4-lite write, address and data offered together
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp; // bready is driven high again by each call and stays high after the answer
    if (n == 50) hang("write timeout");
  endtask
  // axi4-lite read
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp; // rready is driven high again by each call and stays high after the answer
    if (n == 50) hang("read timeout");
  endtask
  // write expecting an okay answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_wr(a, d, resp);
    chk({30'h0, resp}, {30'h0, lsr_pkg::RESP_OKAY}, "write answer");
  endtask
  // read and compare data and answer
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus_rd(a, rdat, resp);
    chk(rdat, exp, "read data");
    chk({30'h0, resp}, {30'h0, lsr_pkg::RESP_OKAY}, "read answer");
  endtask
  // one-cycle parity detect, then check two cycles of {rx, nullify, tx code}
  task automatic par_pulse(input logic [2:0] src, input logic [3:0] e1, input logic [3:0] e2);
    {rx_par_det, tx_tl_par_det, tx_dl_par_det} <= src;
    @(posedge clock);
    {rx_par_det, tx_tl_par_det, tx_dl_par_det} <= 3'h0;
    @(negedge clock);
    chk({28'h0, rx_par_err, tlp_nullify, tx_par_err}, {28'h0, e1}, "parity pulse");
    @(negedge clock);
    chk({28'h0, rx_par_err, tlp_nullify, tx_par_err}, {28'h0, e2}, "parity after");
    @(posedge clock);
  endtask
  // hold reset for 8 cycles
  task automatic do_reset;
    rst <= 1'b1;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
  endtask
  // main sequence
  initial begin
    {rst, rx_par_det, tx_tl_par_det, tx_dl_par_det} = 4'h8;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    train_state = 5'h00;
    train_lanes = 4'h0;
    bad_count = 0;
    compares = 0;
    do_reset;
    rd_chk(lsr_pkg::OFS_STATUS, 32'h0);
    rd_chk(lsr_pkg::OFS_MASK, 32'h0);
    rd_chk(lsr_pkg::OFS_VERR, 32'h0);
    bus_rd(8'h10, rdat, resp);
    chk(rdat, 32'h0, "unmapped data");
    chk({30'h0, resp}, {30'h0, lsr_pkg::RESP_SLVERR}, "unmapped read");
    bus_wr(8'h10, 32'hf, resp);
    chk({30'h0, resp}, {30'h0, lsr_pkg::RESP_SLVERR}, "unmapped write");
    // a write without the low byte lane leaves the register alone
    s_axi_wstrb <= 4'he;
    wr(lsr_pkg::OFS_MASK, 32'hf);
    s_axi_wstrb <= 4'hf;
    rd_chk(lsr_pkg::OFS_MASK, 32'h0);
    // every listed state code but l2 idle, and every lane mode, live and in the link register
    for (int i = 0; i < 7; i++) begin
      train_state <= st_tab[i];
      train_lanes <= ln_tab[i];
      @(posedge clock);
      @(negedge clock);
      chk({27'h0, train_state_out}, {27'h0, st_tab[i]}, "state code");
      chk({28'h0, lane_act}, {28'h0, lx_tab[i]}, "lane mode");
      @(posedge clock);
      rd_chk(lsr_pkg::OFS_LINK, {20'h0, lx_tab[i], 3'h0, st_tab[i]});
    end
    // low-power exit with its interrupt unmasked
    wr(lsr_pkg::OFS_MASK, 32'h1);
    train_state <= lsr_pkg::ST_L2_IDLE;
    repeat (3) @(posedge clock);
    train_state <= 5'h00;
    for (n = 0; n < 5 && lp_exit_n !== 1'b0; n++) @(negedge clock);
    chk({31'h0, lp_exit_n}, 32'h0, "exit pulse");
    @(negedge clock);
    chk({31'h0, lp_exit_n}, 32'h1, "exit pulse width");
    for (n = 0; n < 40 && app_rst; n++) @(negedge clock);
    chk(n, 32'd32, "application reset length");
    @(posedge clock);
    chk_pin(irq, 1'b1, "exit interrupt");
    rd_chk(lsr_pkg::OFS_STATUS, 32'h1);
    wr(lsr_pkg::OFS_STATUS, 32'h1);
    rd_chk(lsr_pkg::OFS_STATUS, 32'h0);
    chk_pin(irq, 1'b0, "interrupt cleared");
    // receive parity, then the core reset it calls for
    par_pulse(3'b100, 4'b1000, 4'h0);
    rd_chk(lsr_pkg::OFS_VERR, 32'h3);
    rd_chk(lsr_pkg::OFS_STATUS, 32'h2);
    chk_pin(irq, 1'b0, "masked interrupt");
    chk_pin(core_rst_req, 1'b1, "reset request rx");
    do_reset;
    rd_chk(lsr_pkg::OFS_VERR, 32'h0);
    // transaction layer then data link layer transmit parity
    par_pulse(3'b010, 4'b0110, 4'h0);
    rd_chk(lsr_pkg::OFS_VERR, 32'h5);
    rd_chk(lsr_pkg::OFS_STATUS, 32'h4);
    wr(lsr_pkg::OFS_VERR, 32'h7);
    wr(lsr_pkg::OFS_STATUS, 32'hf);
    rd_chk(lsr_pkg::OFS_VERR, 32'h0);
    par_pulse(3'b001, 4'b0001, 4'h0);
    rd_chk(lsr_pkg::OFS_VERR, 32'h4);
    rd_chk(lsr_pkg::OFS_STATUS, 32'h8);
    chk_pin(core_rst_req, 1'b1, "reset request tx");
    do_reset;
    // both layers in one cycle: tl code first, dl code pended
    par_pulse(3'b011, 4'b0110, 4'b0001);
    rd_chk(lsr_pkg::OFS_STATUS, 32'hc);
    wr(lsr_pkg::OFS_MASK, 32'h8);
    chk_pin(irq, 1'b1, "dl interrupt");
    wr(lsr_pkg::OFS_STATUS, 32'h8);
    rd_chk(lsr_pkg::OFS_STATUS, 32'h4);
    chk_pin(irq, 1'b0, "dl interrupt cleared");
    wrap_up;
  end
endmodule
bind lsr_status_top lsr_status_sva u_lsr_status_sva (.clock, .rst, .train_state,
  .train_lanes, .rx_par_det, .tx_tl_par_det, .tx_dl_par_det, .lp_exit_n, .lane_act,
  .train_state_out, .rx_par_err, .tx_par_err, .tlp_nullify);
